/* File: shared/can_rx_store_pkg.sv */
// shared constants, message type and helpers for the receive storage link
package can_rx_store_pkg;
    localparam int SLOT_COUNT = 8;
    localparam int NUM_FIFO = 8;
    localparam int NUM_WORD = 16;
    localparam int FIFO_IDX_W = 3;
    localparam int ID_W = 29;
    localparam int STD_ID_W = 11;
    localparam int DLC_W = 4;
    localparam int LABEL_W = 16;
    localparam int CNT_W = 8;
    localparam int DEPTH_CODE_W = 3;
    localparam int DEPTH_STEP = 4;
    localparam int THRESH_SHIFT = 3;
    localparam int PTR_DLC_LSB = 28;
    localparam int IDENT_EXT_BIT = 31;
    localparam logic [7:0] ADV_KEY = 8'hff;
    localparam logic [4:0] RD_IDENT = 5'h10;
    localparam logic [4:0] RD_PTR = 5'h11;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [NUM_FIFO-1:0] EMPTY_RST = 8'hff;

    typedef struct packed {
        logic to_fifo;
        logic [7:0] index;
        logic ext;
        logic [ID_W-1:0] ident;
        logic [DLC_W-1:0] length_code;
        logic [DLC_W-1:0] rule_length_code;
        logic [LABEL_W-1:0] rule_label_value;
        logic [NUM_WORD*32-1:0] data;
    } rx_msg_t;

    // payload bytes carried by a length code
    function automatic logic [6:0] dlc_bytes(input logic [3:0] c);
        logic [6:0] n;
        n = {3'h0, c};
        case (c)
            4'h9: n = 7'h0c;
            4'ha: n = 7'h10;
            4'hb: n = 7'h14;
            4'hc: n = 7'h18;
            4'hd: n = 7'h20;
            4'he: n = 7'h30;
            4'hf: n = 7'h40;
            default: n = {3'h0, c};
        endcase
        return n;
    endfunction
endpackage

/* File: shared/rx_store_if.sv */
// link between the receive storage end and the reader end
`timescale 1ns/1ps
interface rx_store_if;
    import can_rx_store_pkg::*;
    logic rx_valid;
    logic rx_ready;
    rx_msg_t rx_msg;
    logic global_run;
    logic length_check_enable;
    logic length_replace_enable;
    logic msg_lost_irq_enable;
    logic [NUM_FIFO-1:0] fifo_use_enable;
    logic [NUM_FIFO-1:0] fifo_irq_mode;
    logic [NUM_FIFO-1:0] fifo_irq_enable;
    logic [NUM_FIFO-1:0] fifo_full_irq_enable;
    logic [NUM_FIFO-1:0][DEPTH_CODE_W-1:0] fifo_depth_setting;
    logic [NUM_FIFO-1:0][DEPTH_CODE_W-1:0] fifo_irq_threshold;
    logic adv_wr;
    logic [FIFO_IDX_W-1:0] adv_index;
    logic [7:0] adv_value;
    logic nm_wr;
    logic [SLOT_COUNT-1:0] nm_wdata;
    logic flag_clr_wr;
    logic [FIFO_IDX_W-1:0] flag_clr_index;
    logic flag_clr_rx;
    logic flag_clr_full;
    logic flag_clr_lost;
    logic rd_req;
    logic rd_to_fifo;
    logic [7:0] rd_index;
    logic [4:0] rd_word;
    logic rd_valid;
    logic [31:0] rd_data;
    logic [SLOT_COUNT-1:0] slot_new_msg_flag;
    logic [NUM_FIFO-1:0][CNT_W-1:0] fifo_msg_counter;
    logic [NUM_FIFO-1:0] fifo_full_flag;
    logic [NUM_FIFO-1:0] fifo_empty_flag;
    logic [NUM_FIFO-1:0] fifo_irq_request_flag;
    logic [NUM_FIFO-1:0] fifo_full_irq_flag;
    logic [NUM_FIFO-1:0] fifo_lost_flag;
    logic [NUM_FIFO-1:0] fifo_irq;
    logic [NUM_FIFO-1:0] fifo_full_irq;
    logic global_err_irq;

    modport store (
        input rx_valid, rx_msg, global_run, length_check_enable,
        input length_replace_enable, msg_lost_irq_enable, fifo_use_enable,
        input fifo_irq_mode, fifo_irq_enable, fifo_full_irq_enable,
        input fifo_depth_setting, fifo_irq_threshold, adv_wr, adv_index,
        input adv_value, nm_wr, nm_wdata, flag_clr_wr, flag_clr_index,
        input flag_clr_rx, flag_clr_full, flag_clr_lost, rd_req,
        input rd_to_fifo, rd_index, rd_word,
        output rx_ready, rd_valid, rd_data, slot_new_msg_flag,
        output fifo_msg_counter, fifo_full_flag, fifo_empty_flag,
        output fifo_irq_request_flag, fifo_full_irq_flag, fifo_lost_flag,
        output fifo_irq, fifo_full_irq, global_err_irq
    );
    modport reader (
        output rx_valid, rx_msg, global_run, length_check_enable,
        output length_replace_enable, msg_lost_irq_enable, fifo_use_enable,
        output fifo_irq_mode, fifo_irq_enable, fifo_full_irq_enable,
        output fifo_depth_setting, fifo_irq_threshold, adv_wr, adv_index,
        output adv_value, nm_wr, nm_wdata, flag_clr_wr, flag_clr_index,
        output flag_clr_rx, flag_clr_full, flag_clr_lost, rd_req,
        output rd_to_fifo, rd_index, rd_word,
        input rx_ready, rd_valid, rd_data, slot_new_msg_flag,
        input fifo_msg_counter, fifo_full_flag, fifo_empty_flag,
        input fifo_irq_request_flag, fifo_full_irq_flag, fifo_lost_flag,
        input fifo_irq, fifo_full_irq, global_err_irq
    );
endinterface

/* File: hw/rx_store_end.sv */
// receive buffer slots and receive fifos with their flags and requests
`timescale 1ns/1ps
// Summary of operation
// R1 - slots shared, newest message overwrites same slot
// R2 - slot stores raise no interrupt
// R3 - new-message flag set when slot store starts
// R4 - slot holds 64 bytes in sixteen words
// R5 - flag cleared only by writing 0 in run
// R6 - clearing ignored while slot is being stored
// R7 - standard identifier zero above bit 10
// R8 - both enables set store rule length code
// R9 - store matching rule label with each message
// R10 - bytes beyond length code read as zero
// R11 - eight shared fifos, read oldest first
// R12 - each fifo store increments message counter
// R13 - full flag when counter equals depth
// R14 - empty flag when all messages read
// R15 - reader advances by writing FF to field
// R16 - advance only when enabled and not empty
// R17 - never enable fifo with depth code 000
// R18 - per-fifo request by threshold or every message
// R19 - threshold picks eighths of depth or full
// R20 - request flags survive disable, cleared by 0
// R21 - full request when fifo becomes full
// R22 - lost message raises global error request
// R23 - message to full fifo discarded, loss recorded
module rx_store_end
    import can_rx_store_pkg::*;
#(
    parameter int MAX_DEPTH = 32
) (
    // clock, reset and clock enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // link to the reader end
    rx_store_if.store bus
);
    localparam int NENT = SLOT_COUNT + NUM_FIFO * MAX_DEPTH;
    localparam int EW = $clog2(NENT);
    localparam int PW = $clog2(MAX_DEPTH);

    typedef enum {ST_IDLE, ST_DATA} store_state_t;

    function automatic logic [EW-1:0] fifo_ent(
        input logic [FIFO_IDX_W-1:0] f,
        input logic [PW-1:0] p
    );
        return EW'(SLOT_COUNT + int'(f) * MAX_DEPTH + int'(p));
    endfunction

    // two-entry buffer in front of the store engine
    rx_msg_t buf_ff [2];
    logic buf_wp_ff;
    logic buf_rp_ff;
    logic [1:0] buf_cnt_ff;
    logic [1:0] nxt_buf_cnt;
    logic rx_ready_ff;
    logic push;
    logic pop;

    assign push = bus.rx_valid & rx_ready_ff;
    assign nxt_buf_cnt = buf_cnt_ff + 2'(push) - 2'(pop);
    assign bus.rx_ready = rx_ready_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_wp_ff <= 1'b0;
            buf_rp_ff <= 1'b0;
            buf_cnt_ff <= 2'h0;
            rx_ready_ff <= 1'b1;
        end else if (ce) begin
            buf_wp_ff <= buf_wp_ff ^ push;
            buf_rp_ff <= buf_rp_ff ^ pop;
            buf_cnt_ff <= nxt_buf_cnt;
            rx_ready_ff <= nxt_buf_cnt != 2'h2;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            buf_ff[buf_wp_ff] <= bus.rx_msg;
        end
    end

    // store engine
    store_state_t st_ff;
    rx_msg_t head;
    logic [FIFO_IDX_W-1:0] head_f;
    logic [DLC_W-1:0] head_dlc;
    logic [6:0] head_bytes;
    logic [4:0] head_words;
    logic [EW-1:0] head_ent;
    logic head_lost;
    logic start;
    logic last;
    logic done;
    logic done_fifo;
    logic [FIFO_IDX_W-1:0] done_f;
    logic [EW-1:0] ent_ff;
    logic [4:0] wcnt_ff;
    logic [4:0] nwords_ff;
    logic efifo_ff;
    logic [FIFO_IDX_W-1:0] ef_ff;
    logic [NUM_WORD*32-1:0] data_ff;
    logic [PW-1:0] wrp_ff [NUM_FIFO];
    logic [PW-1:0] rdp_ff [NUM_FIFO];
    logic [NUM_FIFO-1:0] en;
    logic [NUM_FIFO-1:0] full_ff;

    assign en = bus.fifo_use_enable;
    assign head = buf_ff[buf_rp_ff];
    assign head_f = head.index[FIFO_IDX_W-1:0];
    assign head_dlc = (bus.length_check_enable & bus.length_replace_enable)
        ? head.rule_length_code : head.length_code; // R8
    assign head_bytes = dlc_bytes(head_dlc);
    assign head_words = 5'((head_bytes + 7'h03) >> 2); // R4
    assign pop = (st_ff == ST_IDLE) && (buf_cnt_ff != 2'h0);
    assign head_lost = pop & head.to_fifo & en[head_f] & full_ff[head_f]; // R23
    assign start = pop & (head.to_fifo ? (en[head_f] & ~full_ff[head_f])
        : (int'(head.index) < SLOT_COUNT));
    assign head_ent = head.to_fifo ? fifo_ent(head_f, wrp_ff[head_f])
        : EW'(head.index); // R1
    assign last = (st_ff == ST_DATA) && (wcnt_ff == nwords_ff - 5'h01);
    assign done = (start && head_words == 5'h00) || last;
    assign done_fifo = start ? head.to_fifo : efifo_ff;
    assign done_f = start ? head_f : ef_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= ST_IDLE;
            ent_ff <= '0;
            wcnt_ff <= 5'h00;
            nwords_ff <= 5'h00;
            efifo_ff <= 1'b0;
            ef_ff <= '0;
            data_ff <= '0;
        end else if (ce) begin
            unique case (st_ff)
                ST_IDLE: if (start) begin
                    ent_ff <= head_ent;
                    nwords_ff <= head_words;
                    wcnt_ff <= 5'h00;
                    efifo_ff <= head.to_fifo;
                    ef_ff <= head_f;
                    data_ff <= head.data;
                    if (head_words != 5'h00) st_ff <= ST_DATA; // R6
                end
                ST_DATA: begin
                    wcnt_ff <= wcnt_ff + 5'h01;
                    if (last) st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // message storage: identifier, length and label, payload words
    logic [31:0] hdr_id [NENT];
    logic [31:0] hdr_ptr [NENT];
    logic [31:0] mem [NENT][NUM_WORD];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (start) begin
                hdr_id[head_ent] <= head.ext ? {1'b1, 2'h0, head.ident}
                    : {3'h0, 18'h0_0000, head.ident[STD_ID_W-1:0]}; // R7
                hdr_ptr[head_ent] <= {head_dlc, 12'h000,
                    head.rule_label_value}; // R9
            end
            if (st_ff == ST_DATA) begin
                mem[ent_ff][wcnt_ff[3:0]] <= data_ff[wcnt_ff[3:0]*32 +: 32];
            end
        end
    end

    // per-fifo counters, pointers, flags and requests
    logic [NUM_FIFO-1:0] inc;
    logic [NUM_FIFO-1:0] dec;
    logic [NUM_FIFO-1:0] empty_ff;
    logic [NUM_FIFO-1:0] irqf_ff;
    logic [NUM_FIFO-1:0] fullf_ff;
    logic [NUM_FIFO-1:0] lostf_ff;
    logic [NUM_FIFO-1:0] irq_ff;
    logic [NUM_FIFO-1:0] full_irq_ff;
    logic err_irq_ff;
    logic [NUM_FIFO-1:0] nxt_full;
    logic [NUM_FIFO-1:0] nxt_empty;
    logic [NUM_FIFO-1:0] nxt_irqf;
    logic [NUM_FIFO-1:0] nxt_fullf;
    logic [NUM_FIFO-1:0] nxt_lostf;
    logic [CNT_W-1:0] cnt_ff [NUM_FIFO];
    logic [CNT_W-1:0] nxt_cnt [NUM_FIFO];
    logic [CNT_W-1:0] depth [NUM_FIFO];
    logic [CNT_W-1:0] level [NUM_FIFO];

    for (genvar g = 0; g < NUM_FIFO; g++) begin : g_fifo
        logic clr_hit;
        assign clr_hit = bus.flag_clr_wr
            && (bus.flag_clr_index == FIFO_IDX_W'(g));
        assign depth[g] = CNT_W'(DEPTH_STEP * int'(bus.fifo_depth_setting[g]));
        assign level[g] = CNT_W'((int'(depth[g])
            * (int'(bus.fifo_irq_threshold[g]) + 1)) >> THRESH_SHIFT); // R19
        assign inc[g] = done && done_fifo && (done_f == FIFO_IDX_W'(g));
        assign dec[g] = bus.adv_wr && (bus.adv_index == FIFO_IDX_W'(g))
            && (bus.adv_value == ADV_KEY) && en[g] && !empty_ff[g]; // R15 R16
        assign nxt_cnt[g] = en[g] ? cnt_ff[g] + CNT_W'(inc[g])
            - CNT_W'(dec[g]) : CNT_ZERO; // R12
        assign nxt_full[g] = en[g] && (nxt_cnt[g] == depth[g]); // R13
        assign nxt_empty[g] = nxt_cnt[g] == CNT_ZERO; // R14
        assign nxt_irqf[g] = (inc[g] && (bus.fifo_irq_mode[g]
            || nxt_cnt[g] == level[g]))
            || (irqf_ff[g] && !(clr_hit && !bus.flag_clr_rx)); // R18 R20
        assign nxt_fullf[g] = (inc[g] && nxt_cnt[g] == depth[g])
            || (fullf_ff[g] && !(clr_hit && !bus.flag_clr_full)); // R21
        assign nxt_lostf[g] = (head_lost && head_f == FIFO_IDX_W'(g))
            || (lostf_ff[g] && !(clr_hit && !bus.flag_clr_lost)); // R23
        assign bus.fifo_msg_counter[g] = cnt_ff[g];

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                cnt_ff[g] <= CNT_ZERO;
                wrp_ff[g] <= '0;
                rdp_ff[g] <= '0;
            end else if (ce) begin
                cnt_ff[g] <= nxt_cnt[g];
                if (!en[g]) begin
                    wrp_ff[g] <= '0;
                    rdp_ff[g] <= '0;
                end else begin
                    // pointers wrap at the configured depth, oldest first
                    if (inc[g]) begin
                        wrp_ff[g] <= (wrp_ff[g] == PW'(depth[g] - 8'h01))
                            ? '0 : wrp_ff[g] + PW'(1); // R11
                    end
                    if (dec[g]) begin
                        rdp_ff[g] <= (rdp_ff[g] == PW'(depth[g] - 8'h01))
                            ? '0 : rdp_ff[g] + PW'(1); // R11
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_ff <= '0;
            empty_ff <= EMPTY_RST;
            irqf_ff <= '0;
            fullf_ff <= '0;
            lostf_ff <= '0;
            irq_ff <= '0;
            full_irq_ff <= '0;
            err_irq_ff <= 1'b0;
        end else if (ce) begin
            full_ff <= nxt_full;
            empty_ff <= nxt_empty;
            irqf_ff <= nxt_irqf;
            fullf_ff <= nxt_fullf;
            lostf_ff <= nxt_lostf;
            irq_ff <= nxt_irqf & bus.fifo_irq_enable; // R18
            full_irq_ff <= nxt_fullf & bus.fifo_full_irq_enable; // R21
            err_irq_ff <= bus.msg_lost_irq_enable && (|nxt_lostf); // R22
        end
    end

    assign bus.fifo_full_flag = full_ff;
    assign bus.fifo_empty_flag = empty_ff;
    assign bus.fifo_irq_request_flag = irqf_ff;
    assign bus.fifo_full_irq_flag = fullf_ff;
    assign bus.fifo_lost_flag = lostf_ff;
    assign bus.fifo_irq = irq_ff;
    assign bus.fifo_full_irq = full_irq_ff;
    assign bus.global_err_irq = err_irq_ff;

    // slot new-message flags; slot stores never touch any request
    logic [SLOT_COUNT-1:0] nm_ff;
    logic [SLOT_COUNT-1:0] nxt_nm;

    for (genvar i = 0; i < SLOT_COUNT; i++) begin : g_slot
        logic set_nm;
        logic clr_nm;
        assign set_nm = start && !head.to_fifo
            && (head.index == 8'(i)); // R3 R2
        assign clr_nm = bus.nm_wr && bus.global_run && !bus.nm_wdata[i]
            && !(st_ff == ST_DATA && !efifo_ff
            && ent_ff == EW'(i)); // R5 R6
        assign nxt_nm[i] = set_nm || (nm_ff[i] && !clr_nm);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nm_ff <= '0;
        end else if (ce) begin
            nm_ff <= nxt_nm;
        end
    end

    assign bus.slot_new_msg_flag = nm_ff;

    // read port: slot entry or fifo head, bytes past the length read zero
    logic [EW-1:0] rd_ent;
    logic [6:0] rd_bytes;
    logic [31:0] rd_word_val;
    logic [31:0] rd_mux;
    logic rd_valid_ff;
    logic [31:0] rd_data_ff;

    always_comb begin
        rd_ent = bus.rd_to_fifo ? fifo_ent(bus.rd_index[FIFO_IDX_W-1:0],
            rdp_ff[bus.rd_index[FIFO_IDX_W-1:0]]) : EW'(bus.rd_index);
        rd_bytes = dlc_bytes(hdr_ptr[rd_ent][PTR_DLC_LSB +: DLC_W]);
        rd_word_val = mem[rd_ent][bus.rd_word[3:0]];
        for (int b = 0; b < 4; b++) begin
            if ({1'b0, bus.rd_word[3:0], 2'(b)} >= rd_bytes) begin
                rd_word_val[b*8 +: 8] = 8'h00; // R10
            end
        end
        if (bus.rd_word == RD_IDENT) begin
            rd_mux = hdr_id[rd_ent];
        end else if (bus.rd_word == RD_PTR) begin
            rd_mux = hdr_ptr[rd_ent];
        end else begin
            rd_mux = rd_word_val;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 32'h0000_0000;
        end else if (ce) begin
            rd_valid_ff <= bus.rd_req;
            if (bus.rd_req) rd_data_ff <= rd_mux;
        end
    end

    assign bus.rd_valid = rd_valid_ff;
    assign bus.rd_data = rd_data_ff;
endmodule

/* File: hw/rx_reader_end.sv */
// reader end: feeds frames, drives configuration, reads and advances
`timescale 1ns/1ps
module rx_reader_end
    import can_rx_store_pkg::*;
(
    // clock, reset and clock enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // link to the storage end
    rx_store_if.reader bus,
    // frames from the protocol channels
    input wire logic u_rx_valid,
    output logic u_rx_ready,
    input wire rx_msg_t u_rx_msg,
    // configuration
    input wire logic u_global_run,
    input wire logic u_len_check_en,
    input wire logic u_len_replace_en,
    input wire logic u_lost_irq_en,
    input wire logic [NUM_FIFO-1:0] u_fifo_use_enable,
    input wire logic [NUM_FIFO-1:0] u_irq_mode,
    input wire logic [NUM_FIFO-1:0] u_irq_enable,
    input wire logic [NUM_FIFO-1:0] u_full_irq_enable,
    input wire logic [NUM_FIFO-1:0][DEPTH_CODE_W-1:0] u_depth,
    input wire logic [NUM_FIFO-1:0][DEPTH_CODE_W-1:0] u_threshold,
    // commands
    input wire logic u_adv_req,
    input wire logic [FIFO_IDX_W-1:0] u_adv_index,
    output logic u_adv_refused,
    input wire logic u_clear_slot_req,
    input wire logic [SLOT_COUNT-1:0] u_clear_slot_mask,
    input wire logic u_clear_flag_req,
    input wire logic [FIFO_IDX_W-1:0] u_clear_flag_index,
    input wire logic [2:0] u_clear_flag_sel,
    // reads
    input wire logic u_rd_req,
    input wire logic u_rd_to_fifo,
    input wire logic [7:0] u_rd_index,
    input wire logic [4:0] u_rd_word,
    output logic u_rd_valid,
    output logic [31:0] u_rd_data
);
    logic hold_ff;
    logic nxt_hold;
    logic take;
    logic [NUM_FIFO-1:0] depth_ok;
    logic adv_ok;

    assign take = u_rx_valid & u_rx_ready;
    assign nxt_hold = (hold_ff & ~bus.rx_ready) | take;
    assign adv_ok = bus.fifo_use_enable[u_adv_index]
        & ~bus.fifo_empty_flag[u_adv_index]; // R16

    for (genvar g = 0; g < NUM_FIFO; g++) begin : g_cfg
        assign depth_ok[g] = u_depth[g] != 3'h0; // R17
    end

    // frame holding register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_ff <= 1'b0;
            u_rx_ready <= 1'b1;
            bus.rx_msg <= '0;
        end else if (ce) begin
            hold_ff <= nxt_hold;
            u_rx_ready <= ~nxt_hold;
            if (take) bus.rx_msg <= u_rx_msg;
        end
    end

    assign bus.rx_valid = hold_ff;

    // configuration
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.global_run <= 1'b0;
            bus.length_check_enable <= 1'b0;
            bus.length_replace_enable <= 1'b0;
            bus.msg_lost_irq_enable <= 1'b0;
            bus.fifo_use_enable <= '0;
            bus.fifo_irq_mode <= '0;
            bus.fifo_irq_enable <= '0;
            bus.fifo_full_irq_enable <= '0;
            bus.fifo_depth_setting <= '0;
            bus.fifo_irq_threshold <= '0;
        end else if (ce) begin
            bus.global_run <= u_global_run;
            bus.length_check_enable <= u_len_check_en;
            bus.length_replace_enable <= u_len_replace_en;
            bus.msg_lost_irq_enable <= u_lost_irq_en;
            bus.fifo_use_enable <= u_fifo_use_enable & depth_ok; // R17
            bus.fifo_irq_mode <= u_irq_mode;
            bus.fifo_irq_enable <= u_irq_enable;
            bus.fifo_full_irq_enable <= u_full_irq_enable;
            bus.fifo_depth_setting <= u_depth;
            bus.fifo_irq_threshold <= u_threshold;
        end
    end

    // advance, flag clears and reads
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.adv_wr <= 1'b0;
            bus.adv_index <= '0;
            bus.adv_value <= 8'h00;
            u_adv_refused <= 1'b0;
            bus.nm_wr <= 1'b0;
            bus.nm_wdata <= '1;
            bus.flag_clr_wr <= 1'b0;
            bus.flag_clr_index <= '0;
            bus.flag_clr_rx <= 1'b1;
            bus.flag_clr_full <= 1'b1;
            bus.flag_clr_lost <= 1'b1;
            bus.rd_req <= 1'b0;
            bus.rd_to_fifo <= 1'b0;
            bus.rd_index <= 8'h00;
            bus.rd_word <= 5'h00;
            u_rd_valid <= 1'b0;
            u_rd_data <= 32'h0000_0000;
        end else if (ce) begin
            bus.adv_wr <= u_adv_req & adv_ok; // R16
            bus.adv_index <= u_adv_index;
            bus.adv_value <= ADV_KEY; // R15
            u_adv_refused <= u_adv_req & ~adv_ok;
            bus.nm_wr <= u_clear_slot_req & bus.global_run; // R5
            bus.nm_wdata <= ~u_clear_slot_mask; // R5
            bus.flag_clr_wr <= u_clear_flag_req;
            bus.flag_clr_index <= u_clear_flag_index;
            bus.flag_clr_rx <= ~u_clear_flag_sel[0]; // R20
            bus.flag_clr_full <= ~u_clear_flag_sel[1];
            bus.flag_clr_lost <= ~u_clear_flag_sel[2];
            bus.rd_req <= u_rd_req;
            bus.rd_to_fifo <= u_rd_to_fifo;
            bus.rd_index <= u_rd_index;
            bus.rd_word <= u_rd_word;
            u_rd_valid <= bus.rd_valid;
            u_rd_data <= bus.rd_data;
        end
    end
endmodule

/* File: testbench/rx_store_props.sv */
// assertions on the storage link, watching fifo 0
`timescale 1ns/1ps
module rx_store_props
    import can_rx_store_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // requests
    input wire logic rd_req,
    input wire logic rd_valid,
    input wire logic adv_wr,
    input wire logic flag_clr_wr,
    input wire logic [NUM_FIFO-1:0][DEPTH_CODE_W-1:0] fifo_depth_setting,
    // status
    input wire logic [NUM_FIFO-1:0][CNT_W-1:0] fifo_msg_counter,
    input wire logic [NUM_FIFO-1:0] fifo_full_flag,
    input wire logic [NUM_FIFO-1:0] fifo_empty_flag,
    input wire logic [NUM_FIFO-1:0] fifo_irq_request_flag
);
    logic [CNT_W-1:0] cnt;
    assign cnt = fifo_msg_counter[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_rd; rd_req ##1 rd_valid; endsequence
    property p_rd; rd_req |-> s_rd; endproperty
    a_rd: assert property (p_rd) else $error("read unanswered");
    property p_rdv; rd_valid |-> $past(rd_req); endproperty
    a_rdv: assert property (p_rdv) else $error("stray read");
    property p_full;
        fifo_full_flag[0] |-> cnt == {3'h0, fifo_depth_setting[0], 2'h0};
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");
    property p_emp; cnt == CNT_ZERO |-> fifo_empty_flag[0]; endproperty
    a_emp: assert property (p_emp) else $error("empty missing");
    property p_emp2; fifo_empty_flag[0] |-> cnt == CNT_ZERO; endproperty
    a_emp2: assert property (p_emp2) else $error("empty early");
    property p_inc; cnt > $past(cnt) |-> cnt == $past(cnt) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("count jump");
    property p_dec; cnt < $past(cnt) && cnt != CNT_ZERO |-> $past(adv_wr);
    endproperty
    a_dec: assert property (p_dec) else $error("count drop");
    property p_req;
        fifo_irq_request_flag[0] && !flag_clr_wr |=> fifo_irq_request_flag[0];
    endproperty
    a_req: assert property (p_req) else $error("request lost");
endmodule

/* File: testbench/testbench.sv */
// bench joining the storage end and the reader end
`timescale 1ns/1ps
module testbench;
    import can_rx_store_pkg::*;
    logic clk = 0, rstn = 0, ce = 1, u_rx_valid = 0, u_global_run = 1;
    logic u_len_check_en = 1, u_len_replace_en = 1, u_lost_irq_en = 1;
    logic u_adv_req = 0, u_clear_slot_req = 0, u_clear_flag_req = 0;
    logic u_rd_req = 0, u_rd_to_fifo = 0, u_rx_ready, u_adv_refused, u_rd_valid;
    logic [7:0] u_fifo_use_enable = 8'h01, u_irq_mode = 8'h00;
    logic [7:0] u_irq_enable = 8'h01, u_full_irq_enable = 8'h01;
    logic [7:0][2:0] u_depth = 24'h00_0001, u_threshold = 24'h00_0007;
    logic [2:0] u_adv_index = 3'h0, u_clear_flag_index = 3'h0;
    logic [2:0] u_clear_flag_sel = 3'h1;
    logic [7:0] u_clear_slot_mask = 8'h04, u_rd_index = 8'h00;
    logic [4:0] u_rd_word = 5'h00;
    logic [31:0] u_rd_data, d;
    rx_msg_t u_rx_msg = '0;
    int n_mismatch = 0, compares = 0;
    rx_store_if bus ();
    rx_store_end u_rx_store_end (.*);
    rx_reader_end u_rx_reader_end (.*);
    rx_store_props u_rx_store_props (.clk, .rstn, .rd_req(bus.rd_req),
        .rd_valid(bus.rd_valid), .adv_wr(bus.adv_wr),
        .flag_clr_wr(bus.flag_clr_wr), .fifo_full_flag(bus.fifo_full_flag),
        .fifo_depth_setting(bus.fifo_depth_setting),
        .fifo_msg_counter(bus.fifo_msg_counter),
        .fifo_empty_flag(bus.fifo_empty_flag),
        .fifo_irq_request_flag(bus.fifo_irq_request_flag));
    always #10 clk = ~clk;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(logic f, logic [7:0] i, logic [28:0] id);
        logic r;
        u_rx_msg = '{f, i, 1'b0, id, 4'h3, 4'h5, 16'h4c21, {128{4'ha}}};
        u_rx_valid = 1;
        do begin
            r = u_rx_ready;
            tick(1);
        end while (!r);
        u_rx_valid = 0;
        tick(1);
    endtask
    task automatic rd(logic f, logic [4:0] w);
        u_rd_to_fifo = f;
        u_rd_index = f ? 8'h00 : 8'h02;
        u_rd_word = w;
        u_rd_req = 1;
        tick(1);
        u_rd_req = 0;
        while (u_rd_valid !== 1'b1) tick(1);
        d = u_rd_data;
    endtask
    task automatic adv(output logic r);
        u_adv_req = 1;
        tick(1);
        u_adv_req = 0;
        r = u_adv_refused;
        tick(2);
        r = r | u_adv_refused;
    endtask
    task automatic t_slot;
        send(0, 8'h02, 29'h1abc_d123);
        tick(30);
        chk("flag", 1'h1, bus.slot_new_msg_flag[2]);
        chk("no irq", 32'h0, {bus.fifo_irq, bus.fifo_full_irq,
            bus.global_err_irq});
        rd(0, RD_IDENT);
        chk("ident", 32'h0000_0123, d);
        rd(0, RD_PTR);
        chk("ptr", 32'h5000_4c21, d);
        rd(0, 5'h01);
        chk("word", 32'h0000_00aa, d);
        u_clear_slot_req = 1;
        tick(1);
        u_clear_slot_req = 0;
        tick(3);
        chk("clear", 1'h0, bus.slot_new_msg_flag[2]);
    endtask
    task automatic t_fifo;
        logic r;
        for (int i = 0; i < 5; i++) send(1, 8'h00, 29'(i + 16));
        tick(40);
        chk("count", 8'h04, bus.fifo_msg_counter[0]);
        chk("full", 1'h1, bus.fifo_full_flag[0]);
        chk("full irq", 1'h1, bus.fifo_full_irq[0]);
        chk("req", 1'h1, bus.fifo_irq[0]);
        chk("lost", 1'h1, bus.global_err_irq);
        for (int i = 0; i < 4; i++) begin
            rd(1, RD_IDENT);
            chk("head", 32'(i + 16), d);
            adv(r);
        end
        chk("empty", 1'h1, bus.fifo_empty_flag[0]);
        adv(r);
        chk("refused", 1'h1, r);
        u_fifo_use_enable = 8'h00;
        tick(3);
        chk("kept", 1'h1, bus.fifo_irq_request_flag[0]);
        u_clear_flag_req = 1;
        tick(1);
        u_clear_flag_req = 0;
        tick(3);
        chk("cleared", 1'h0, bus.fifo_irq_request_flag[0]);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        tick(2);
        rstn = 1;
        tick(2);
        t_slot();
        t_fifo();
        wrap_up();
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
